// ### design/lugc_clk_div.sv
// Reference clock generator: toggles every div cycles of clk.
// Assumes div is a static register value of at least 1.
`timescale 1ns/10ps
`include "lugc_regs.svh"
module lugc_clk_div (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] div,
    output logic            clk_out
);
    import lugc_pkg::*;
    typedef struct packed {
        logic [7:0] cnt;
        logic       q;
    } lugc_div_st_s;
    lugc_div_st_s st_r, st_nxt;
    always_comb begin
        st_nxt = st_r;
        if (st_r.cnt + 8'h01 >= div) begin
            st_nxt.cnt = 8'h00;
            st_nxt.q   = ~st_r.q;
        end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    assign clk_out = st_r.q;
endmodule : lugc_clk_div

// ### design/lugc_los_det.sv
// Consecutive-zero loss detector for the receive line.
// Assumes rx_sym_sync is already synchronised and rx_sym_vld marks a symbol.
`timescale 1ns/10ps
`include "lugc_regs.svh"
module lugc_los_det (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ext_window,
    input  wire logic rx_sym_vld,
    input  wire logic rx_sym,
    output logic      loss
);
    import lugc_pkg::*;
    typedef struct packed {
        logic [12:0] cnt;
        logic        loss;
    } lugc_los_st_s;
    lugc_los_st_s st_r, st_nxt;
    logic [12:0]  limit;
    always_comb begin
        limit = ext_window ? `LUGC_LOS_LONG : `LUGC_LOS_SHORT;
        st_nxt = st_r;
        if (rx_sym_vld) begin
            if (rx_sym) begin
                st_nxt.cnt  = 13'h0000;
                st_nxt.loss = 1'b0;
            end else begin
                if (st_r.cnt < limit)
                    st_nxt.cnt = st_r.cnt + 13'h0001;
                if (st_r.cnt + 13'h0001 >= limit)
                    st_nxt.loss = 1'b1;
            end
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    assign loss = st_r.loss;

    property p_short_loss;
        @(posedge clk) disable iff (sys_rst)
        (!ext_window && rx_sym_vld && !rx_sym && st_r.cnt == 13'd174)
            |=> loss;
    endproperty
    a_short_loss: assert property (p_short_loss)
        else $error("loss not raised at 175 zeros");
    property p_long_loss;
        @(posedge clk) disable iff (sys_rst)
        (ext_window && rx_sym_vld && !rx_sym && st_r.cnt < 13'd4095
         && !loss) |=> !loss;
    endproperty
    a_long_loss: assert property (p_long_loss)
        else $error("loss raised before 4096 zeros");
    property p_restart;
        @(posedge clk) disable iff (sys_rst)
        (rx_sym_vld && rx_sym) |=> (st_r.cnt == 13'h0000 && !loss);
    endproperty
    a_restart: assert property (p_restart)
        else $error("zero count not restarted by a one");
    c_loss: cover property (@(posedge clk) disable iff (sys_rst)
        $rose(loss));
endmodule : lugc_los_det

// ### design/lugc_pkg.sv
// Types of the line unit global configuration block.
// Constants live in lugc_regs.svh.
package lugc_pkg;
    typedef enum logic [3:0] {
        LUGC_F_NONE, LUGC_F_1544, LUGC_F_2048, LUGC_F_3088, LUGC_F_4096,
        LUGC_F_6176, LUGC_F_8192, LUGC_F_12352, LUGC_F_16384
    } lugc_freq_e;
    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } lugc_axi_req_s;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } lugc_axi_rsp_s;
endpackage : lugc_pkg

// ### design/lugc_regs.svh
// Constants of the line unit global configuration block.
// Included by the package user files; holds definitions only.
// Overview of operation
// - With extended window set, loss declared after 4096 consecutive zeros.
// - With extended window clear, loss declared after 175 consecutive zeros.
// - Test tristate bit 0 of control one, default 0, floats all outputs; the design floats only the reference clock pin.
// - Output rate field bits 5-4, default 00, picks 1.544 to 12.352 MHz.
// - Input rate field bits 3-0, default 0001 = 1.544, 0000 = 2.048 MHz.
// - Input codes 1000..1011 mean 4.096, 3.088, 8.192, 6.176 MHz.
// - Codes 1100..1111 mean 16.384, 12.352, 2.048, 1.544 MHz.
`ifndef LUGC_REGS_SVH
`define LUGC_REGS_SVH
`define LUGC_OFF_CTRL1     8'h00
`define LUGC_OFF_CTRL2     8'h04
`define LUGC_OFF_OCLK      8'h08
`define LUGC_OFF_ICLK      8'h0c
`define LUGC_OFF_STATUS    8'h10
`define LUGC_OFF_IRQ_STAT  8'h14
`define LUGC_OFF_IRQ_MASK  8'h18
`define LUGC_BIT_TRISTATE  0
`define LUGC_BIT_EXT_LOSS  1
`define LUGC_BIT_FORCE0    7
`define LUGC_RST_CTRL1     8'h00
`define LUGC_RST_CTRL2     8'h00
`define LUGC_RST_OCLK      8'h00
`define LUGC_RST_ICLK      8'h01
`define LUGC_LOS_SHORT     13'd175
`define LUGC_LOS_LONG      13'd4096
`define LUGC_CODE_2048     4'h0
`define LUGC_CODE_1544     4'h1
`define LUGC_CODE_4096     4'h8
`define LUGC_CODE_3088     4'h9
`define LUGC_CODE_8192     4'ha
`define LUGC_CODE_6176     4'hb
`define LUGC_CODE_16384    4'hc
`define LUGC_CODE_12352    4'hd
`define LUGC_CODE_2048B    4'he
`define LUGC_CODE_1544B    4'hf
`define LUGC_DIV_1544      8'd8
`define LUGC_DIV_3088      8'd4
`define LUGC_DIV_6176      8'd2
`define LUGC_DIV_12352     8'd1
`endif

// ### design/lugc_top.sv
// Global configuration of the line interface unit, AXI4-Lite slave.
// Assumes clk is the master clock; rx line inputs are asynchronous pins.
`timescale 1ns/10ps
`include "lugc_regs.svh"
module lugc_top (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire lugc_pkg::lugc_axi_req_s axi_req,
    output lugc_pkg::lugc_axi_rsp_s      axi_rsp,
    input  wire logic          rx_sym_vld_pin,
    input  wire logic          rx_sym_pin,
    output logic               receive_signal_loss,
    output logic               reference_clock_out_pin,
    output logic               reference_clock_out_oe,
    output logic               test_tristate,
    output logic [3:0]         input_clock_rate_sel,
    output logic               irq
);
    import lugc_pkg::*;

    typedef struct packed {
        logic [7:0]  ctrl1;
        logic [7:0]  ctrl2;
        logic [7:0]  oclk;
        logic [7:0]  iclk;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [1:0]  vld_sync;
        logic [1:0]  sym_sync;
        logic        loss_d;
        logic        loss_o;
        logic        refclk_o;
        logic        oe_o;
        logic        irq_o;
        logic        aw_rdy;
        logic        w_rdy;
        logic        tts_o;
    } lugc_top_st_s;

    lugc_top_st_s st_r, st_nxt;
    logic         loss_w;
    logic         refclk_w;
    logic [7:0]   div_w;
    logic         aw_hs, w_hs, wr_do, ar_hs;
    logic [31:0]  rd_word;
    logic         rd_ok;

    // Decodes an input rate code; NONE marks the reserved codes.
    function automatic lugc_freq_e freq_of(input logic [3:0] code);
        case (code)
            `LUGC_CODE_2048:  freq_of = LUGC_F_2048;
            `LUGC_CODE_1544:  freq_of = LUGC_F_1544;
            `LUGC_CODE_4096:  freq_of = LUGC_F_4096;
            `LUGC_CODE_3088:  freq_of = LUGC_F_3088;
            `LUGC_CODE_8192:  freq_of = LUGC_F_8192;
            `LUGC_CODE_6176:  freq_of = LUGC_F_6176;
            `LUGC_CODE_16384: freq_of = LUGC_F_16384;
            `LUGC_CODE_12352: freq_of = LUGC_F_12352;
            `LUGC_CODE_2048B: freq_of = LUGC_F_2048;
            `LUGC_CODE_1544B: freq_of = LUGC_F_1544;
            default:          freq_of = LUGC_F_NONE;
        endcase
    endfunction : freq_of

    // Byte-lane merge; only lane 0 carries register data.
    function automatic logic [7:0] merge8(input logic [7:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        merge8 = s[0] ? d[7:0] : old;
    endfunction : merge8

    // Reference divider per output rate select; rates scale the base clock.
    always_comb begin
        case (st_r.oclk[5:4])
            2'b00:   div_w = `LUGC_DIV_1544;
            2'b01:   div_w = `LUGC_DIV_3088;
            2'b10:   div_w = `LUGC_DIV_6176;
            default: div_w = `LUGC_DIV_12352;
        endcase
    end

    lugc_los_det u_los (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .ext_window (st_r.ctrl1[`LUGC_BIT_EXT_LOSS]),
        .rx_sym_vld (st_r.vld_sync[1]),
        .rx_sym     (st_r.sym_sync[1]),
        .loss       (loss_w)
    );

    lugc_clk_div u_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .div     (div_w),
        .clk_out (refclk_w)
    );

    assign aw_hs = axi_req.awvalid && st_r.aw_rdy;
    assign w_hs  = axi_req.wvalid && st_r.w_rdy;
    assign wr_do = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    assign ar_hs = axi_req.arvalid && st_r.arready;

    always_comb begin
        rd_ok   = 1'b1;
        rd_word = 32'h0000_0000;
        case (axi_req.araddr[7:0])
            `LUGC_OFF_CTRL1:    rd_word[7:0] = st_r.ctrl1;
            `LUGC_OFF_CTRL2:    rd_word[7:0] = st_r.ctrl2;
            `LUGC_OFF_OCLK:     rd_word[7:0] = st_r.oclk;
            `LUGC_OFF_ICLK:     rd_word[7:0] = st_r.iclk;
            `LUGC_OFF_STATUS: begin
                rd_word[0] = st_r.loss_o;
                rd_word[1] = (freq_of(st_r.iclk[3:0]) == LUGC_F_NONE);
            end
            `LUGC_OFF_IRQ_STAT: rd_word[1:0] = st_r.irq_stat;
            `LUGC_OFF_IRQ_MASK: rd_word[1:0] = st_r.irq_mask;
            default:            rd_ok = 1'b0;
        endcase
        if (axi_req.araddr[31:8] != 24'h000000) begin
            rd_ok   = 1'b0;
            rd_word = 32'h0000_0000;
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.vld_sync = {st_r.vld_sync[0], rx_sym_vld_pin};
        st_nxt.sym_sync = {st_r.sym_sync[0], rx_sym_pin};
        st_nxt.loss_d   = loss_w;
        st_nxt.loss_o   = loss_w;
        if (aw_hs) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = axi_req.awaddr[7:0];
        end
        if (w_hs) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.w_data = axi_req.wdata;
            st_nxt.w_strb = axi_req.wstrb;
        end
        if (st_r.bvalid && axi_req.bready)
            st_nxt.bvalid = 1'b0;
        if (wr_do) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = 2'b00;
            case (st_r.aw_addr)
                `LUGC_OFF_CTRL1:
                    st_nxt.ctrl1 = merge8(st_r.ctrl1, st_r.w_data,
                                          st_r.w_strb);
                `LUGC_OFF_CTRL2:
                    st_nxt.ctrl2 = merge8(st_r.ctrl2, st_r.w_data,
                                          st_r.w_strb);
                `LUGC_OFF_OCLK:
                    st_nxt.oclk = merge8(st_r.oclk, st_r.w_data,
                                         st_r.w_strb);
                `LUGC_OFF_ICLK:
                    st_nxt.iclk = merge8(st_r.iclk, st_r.w_data,
                                         st_r.w_strb);
                `LUGC_OFF_IRQ_STAT:
                    if (st_r.w_strb[0])
                        st_nxt.irq_stat = st_r.irq_stat & ~st_r.w_data[1:0];
                `LUGC_OFF_IRQ_MASK:
                    if (st_r.w_strb[0])
                        st_nxt.irq_mask = st_r.w_data[1:0];
                `LUGC_OFF_STATUS: ;
                default: st_nxt.bresp = 2'b10;
            endcase
        end
        // Events set after the clear so a same-cycle event is kept
        if (loss_w && !st_r.loss_d)
            st_nxt.irq_stat[0] = 1'b1;
        if (!loss_w && st_r.loss_d)
            st_nxt.irq_stat[1] = 1'b1;
        if (ar_hs) begin
            st_nxt.arready = 1'b0;
            st_nxt.rvalid  = 1'b1;
            st_nxt.rdata   = rd_word;
            st_nxt.rresp   = rd_ok ? 2'b00 : 2'b10;
        end
        if (st_r.rvalid && axi_req.rready) begin
            st_nxt.rvalid  = 1'b0;
            st_nxt.arready = 1'b1;
        end
        // Tristate test floats only the reference clock pin and raises test_tristate
        st_nxt.oe_o     = !st_nxt.ctrl1[`LUGC_BIT_TRISTATE];
        st_nxt.refclk_o = refclk_w;
        st_nxt.irq_o    = |(st_nxt.irq_stat & st_nxt.irq_mask);
        // Ready is registered so every top output leaves a flop
        st_nxt.aw_rdy   = !st_nxt.aw_got && !st_nxt.bvalid;
        st_nxt.w_rdy    = !st_nxt.w_got && !st_nxt.bvalid;
        st_nxt.tts_o    = st_nxt.ctrl1[`LUGC_BIT_TRISTATE];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r          <= '0;
            st_r.ctrl1    <= `LUGC_RST_CTRL1;
            st_r.ctrl2    <= `LUGC_RST_CTRL2;
            st_r.oclk     <= `LUGC_RST_OCLK;
            st_r.iclk     <= `LUGC_RST_ICLK;
            st_r.arready  <= 1'b1;
            st_r.aw_rdy   <= 1'b1;
            st_r.w_rdy    <= 1'b1;
            st_r.oe_o     <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign axi_rsp.awready = st_r.aw_rdy;
    assign axi_rsp.wready  = st_r.w_rdy;
    assign axi_rsp.bvalid  = st_r.bvalid;
    assign axi_rsp.bresp   = st_r.bresp;
    assign axi_rsp.arready = st_r.arready;
    assign axi_rsp.rvalid  = st_r.rvalid;
    assign axi_rsp.rdata   = st_r.rdata;
    assign axi_rsp.rresp   = st_r.rresp;
    assign receive_signal_loss     = st_r.loss_o;
    assign reference_clock_out_pin = st_r.refclk_o;
    assign reference_clock_out_oe  = st_r.oe_o;
    assign test_tristate           = st_r.tts_o;
    assign input_clock_rate_sel    = st_r.iclk[3:0];
    assign irq                     = st_r.irq_o;

    property p_tristate;
        @(posedge clk) disable iff (sys_rst)
        st_r.ctrl1[`LUGC_BIT_TRISTATE] |-> !reference_clock_out_oe;
    endproperty
    a_tristate: assert property (p_tristate)
        else $error("pin driven while tristate test set");
    property p_iclk_rst;
        @(posedge clk) $fell(sys_rst) |-> input_clock_rate_sel == 4'h1;
    endproperty
    a_iclk_rst: assert property (p_iclk_rst)
        else $error("input rate select not 0001 after reset");
    property p_irq;
        @(posedge clk) disable iff (sys_rst)
        (st_r.irq_stat & st_r.irq_mask) != 2'b00 |-> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("unmasked status without interrupt");
    property p_loss_irq;
        @(posedge clk) disable iff (sys_rst)
        $rose(loss_w) |=> st_r.irq_stat[0];
    endproperty
    a_loss_irq: assert property (p_loss_irq)
        else $error("loss event not latched");
    property p_resp;
        @(posedge clk) disable iff (sys_rst)
        ar_hs |=> axi_rsp.rvalid;
    endproperty
    a_resp: assert property (p_resp)
        else $error("read answer late");
    // Bus handshake checks
    property p_refused;
        @(posedge clk) disable iff (sys_rst)
        axi_rsp.bvalid |-> (!axi_rsp.awready && !axi_rsp.wready);
    endproperty
    a_refused: assert property (p_refused)
        else $error("new write accepted under a pending answer");
    property p_ar_block;
        @(posedge clk) disable iff (sys_rst)
        axi_rsp.rvalid |-> !axi_rsp.arready;
    endproperty
    a_ar_block: assert property (p_ar_block)
        else $error("read address accepted under a pending answer");
    property p_wr_answer;
        @(posedge clk) disable iff (sys_rst)
        (aw_hs && w_hs) |-> ##2 axi_rsp.bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write answer not given two cycles after take");
    property p_b_done;
        @(posedge clk) disable iff (sys_rst)
        (axi_rsp.bvalid && axi_req.bready) |=> !axi_rsp.bvalid;
    endproperty
    a_b_done: assert property (p_b_done)
        else $error("write answer kept after it was taken");
    property p_r_done;
        @(posedge clk) disable iff (sys_rst)
        (axi_rsp.rvalid && axi_req.rready)
            |=> (!axi_rsp.rvalid && axi_rsp.arready);
    endproperty
    a_r_done: assert property (p_r_done)
        else $error("read channel not freed after answer taken");
    property p_rd_err;
        @(posedge clk) disable iff (sys_rst)
        (ar_hs && !rd_ok)
            |=> (axi_rsp.rresp == 2'b10 && axi_rsp.rdata == 32'h0000_0000);
    endproperty
    a_rd_err: assert property (p_rd_err)
        else $error("unmapped read not refused with zero data");
    // Fastest rate toggles the reference every clock
    property p_ref_fast;
        @(posedge clk) disable iff (sys_rst)
        ($past(st_r.oclk[5:4]) == 2'b11)
            |-> (refclk_w != $past(refclk_w));
    endproperty
    a_ref_fast: assert property (p_ref_fast)
        else $error("reference clock not at fastest rate");
    property p_iclk_wr;
        @(posedge clk) disable iff (sys_rst)
        (wr_do && st_r.aw_addr == `LUGC_OFF_ICLK && st_r.w_strb[0])
            |=> (input_clock_rate_sel == $past(st_r.w_data[3:0]));
    endproperty
    a_iclk_wr: assert property (p_iclk_wr)
        else $error("input rate select does not follow write");
    property p_tts_wr;
        @(posedge clk) disable iff (sys_rst)
        (wr_do && st_r.aw_addr == `LUGC_OFF_CTRL1 && st_r.w_strb[0])
            |=> (test_tristate == $past(st_r.w_data[`LUGC_BIT_TRISTATE]));
    endproperty
    a_tts_wr: assert property (p_tts_wr)
        else $error("tristate test output does not follow write");
    property p_tts_oe;
        @(posedge clk) disable iff (sys_rst)
        test_tristate |-> !reference_clock_out_oe;
    endproperty
    a_tts_oe: assert property (p_tts_oe)
        else $error("reference pin driven during tristate test");
    property p_loss_fall;
        @(posedge clk) disable iff (sys_rst)
        $fell(loss_w) |=> st_r.irq_stat[1];
    endproperty
    a_loss_fall: assert property (p_loss_fall)
        else $error("loss end event not latched");
    property p_loss_out;
        @(posedge clk) disable iff (sys_rst)
        $rose(loss_w) |=> receive_signal_loss;
    endproperty
    a_loss_out: assert property (p_loss_out)
        else $error("loss not shown on output");
    property p_wr_ok;
        @(posedge clk) disable iff (sys_rst)
        (wr_do && st_r.aw_addr == `LUGC_OFF_CTRL2)
            |=> (axi_rsp.bvalid && axi_rsp.bresp == 2'b00);
    endproperty
    a_wr_ok: assert property (p_wr_ok)
        else $error("control two write not accepted");
    c_write: cover property (@(posedge clk) disable iff (sys_rst)
        st_r.bvalid && axi_req.bready);
    c_read: cover property (@(posedge clk) disable iff (sys_rst)
        st_r.rvalid && axi_req.rready);
    c_tri: cover property (@(posedge clk) disable iff (sys_rst)
        $fell(reference_clock_out_oe));
endmodule : lugc_top

// ### dv/lugc_line_src.sv
// Model of the receive line feeding symbols to the block.
// Assumes the bench calls send() from its main sequence only.
`timescale 1ns/10ps
module lugc_line_src (
    input  wire logic clk,
    output logic      sym_vld,
    output logic      sym
);
    logic vld_r  = 1'b0;
    logic dat_r  = 1'b0;
    logic idle_r = 1'b0;

    // Between bursts the line carries noise, never a held last value
    always @(posedge clk) begin
        idle_r <= ~idle_r;
    end

    assign sym_vld = vld_r;
    assign sym     = vld_r ? dat_r : idle_r;

    // n zeros in a row, or one mark when n is 0; slow leaves gaps
    task automatic send(input int n, input bit slow);
        for (int i = 0; i < ((n > 0) ? n : 1); i++) begin
            @(posedge clk);
            dat_r <= (n == 0);
            vld_r <= 1'b1;
            if (slow) begin
                @(posedge clk);
                vld_r <= 1'b0;
            end
        end
        @(posedge clk);
        vld_r <= 1'b0;
    endtask : send
endmodule : lugc_line_src

// ### dv/tb.sv
// Self-checking bench for the line unit global configuration block.
// Assumes the AXI4-Lite map and latencies of the design's hand-over.
`timescale 1ns/10ps
`include "lugc_regs.svh"
module tb;
    import lugc_pkg::*;

    logic          clk;
    logic          sys_rst;
    lugc_axi_req_s req;
    lugc_axi_rsp_s rsp;
    logic          vld;
    logic          sym;
    logic          loss;
    logic          rpin;
    logic          roe;
    logic          tts;
    logic [3:0]    icsel;
    logic          irq;
    int            fails = 0;
    int            checks = 0;
    logic [31:0]   d;
    logic [1:0]    r;
    logic [7:0]    half;
    logic [3:0]    codes [10] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'ha,
                                  4'hb, 4'hc, 4'hd, 4'he, 4'hf};

    lugc_top i_dut (
        .clk                     (clk),
        .sys_rst                 (sys_rst),
        .axi_req                 (req),
        .axi_rsp                 (rsp),
        .rx_sym_vld_pin          (vld),
        .rx_sym_pin              (sym),
        .receive_signal_loss     (loss),
        .reference_clock_out_pin (rpin),
        .reference_clock_out_oe  (roe),
        .test_tristate           (tts),
        .input_clock_rate_sel    (icsel),
        .irq                     (irq)
    );

    lugc_line_src i_src (
        .clk     (clk),
        .sym_vld (vld),
        .sym     (sym)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude;
        $display("Checks %0d, fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        req.awaddr  <= {24'h0, a};
        req.wdata   <= v;
        req.wstrb   <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        req.araddr  <= {24'h0, a};
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask : rd

    // Two toggles first so a rate change mid-count is not measured
    task automatic half_period;
        logic v;
        repeat (2) begin
            v = rpin;
            while (rpin === v) @(posedge clk);
        end
        v = rpin;
        half = 8'h00;
        while (rpin === v && half < 8'h40) begin
            @(posedge clk);
            half++;
        end
    endtask : half_period

    initial begin
        #(30000 * 40);
        fails++;
        conclude();
    end

    initial begin
        req     = '0;
        sys_rst = 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`LUGC_OFF_CTRL1); chk(d, 32'h0);
        rd(`LUGC_OFF_CTRL2); chk(d, 32'h0);
        rd(`LUGC_OFF_OCLK); chk(d, 32'h0);
        rd(`LUGC_OFF_ICLK); chk(d, 32'h1);
        chk(32'(icsel), 32'h1);
        chk(32'(roe), 32'h1);
        wr(`LUGC_OFF_CTRL2, 32'h0); chk(32'(r), 32'h0);
        rd(8'h1c); chk(32'(r), 32'h2);
        chk(d, 32'h0);
        wr(8'h1c, 32'h0); chk(32'(r), 32'h2);
        foreach (codes[i]) begin
            wr(`LUGC_OFF_ICLK, 32'(codes[i]));
            rd(`LUGC_OFF_ICLK); chk(d, 32'(codes[i]));
            chk(32'(icsel), 32'(codes[i]));
            rd(`LUGC_OFF_STATUS); chk((d >> 1) & 32'h1, 32'h0);
        end
        for (int k = 0; k < 4; k++) begin
            wr(`LUGC_OFF_OCLK, 32'(k << 4));
            rd(`LUGC_OFF_OCLK); chk(d, 32'(k << 4));
            half_period();
            chk(32'(half), 32'(8 >> k));
        end
        wr(`LUGC_OFF_CTRL1, 32'h1);
        repeat (2) @(posedge clk);
        chk(32'(tts), 32'h1);
        chk(32'(roe), 32'h0);
        wr(`LUGC_OFF_CTRL1, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(roe), 32'h1);
        // A mark mid-run must restart the zero count
        i_src.send(100, 1'b0);
        i_src.send(0, 1'b0);
        i_src.send(174, 1'b0);
        repeat (8) @(posedge clk);
        chk(32'(loss), 32'h0);
        i_src.send(1, 1'b0);
        repeat (8) @(posedge clk);
        chk(32'(loss), 32'h1);
        rd(`LUGC_OFF_STATUS); chk(d & 32'h1, 32'h1);
        chk(32'(irq), 32'h0);
        wr(`LUGC_OFF_IRQ_MASK, 32'h1);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h1);
        wr(`LUGC_OFF_IRQ_STAT, 32'h1);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h0);
        i_src.send(0, 1'b0);
        repeat (8) @(posedge clk);
        chk(32'(loss), 32'h0);
        chk(32'(irq), 32'h0);
        rd(`LUGC_OFF_IRQ_STAT); chk(d & 32'h3, 32'h2);
        wr(`LUGC_OFF_CTRL1, 32'h2);
        i_src.send(4095, 1'b1);
        repeat (8) @(posedge clk);
        chk(32'(loss), 32'h0);
        i_src.send(1, 1'b0);
        repeat (8) @(posedge clk);
        chk(32'(loss), 32'h1);
        conclude();
    end
endmodule : tb
